// *** cac_pkg.sv ***
/*
 package for the counter array control block: sfr addresses, control
 register fields, reset values and clock source codes.
 assumes an 8-bit special function register space.
*/
package cac_pkg;
    localparam logic [7:0] CAC_ADDR_CTRL_ZERO  = 8'ha4;
    localparam logic [7:0] CAC_ADDR_CTRL_ONE   = 8'hbc;
    localparam logic [7:0] CAC_ADDR_STATUS     = 8'ha5;
    localparam logic [7:0] CAC_ADDR_PRESC_ZERO = 8'hfb;
    localparam logic [7:0] CAC_ADDR_PRESC_ONE  = 8'hfc;
    localparam logic [7:0] CAC_CTRL_RESET      = 8'h00;
    localparam logic [7:0] CAC_PRESC_RESET     = 8'h10;
    localparam logic [7:0] CAC_STATUS_RESET    = 8'h00;
    localparam logic [7:0] CAC_CTRL_MASK_ZERO  = 8'hf7;
    localparam logic [7:0] CAC_CTRL_MASK_ONE   = 8'h77;
    localparam logic [7:0] CAC_PRESC_MASK      = 8'h1f;
    localparam int         CAC_BIT_START_ALL   = 7;
    localparam int         CAC_BIT_RUN         = 6;
    localparam int         CAC_BIT_OVF_IRQ_EN  = 5;
    localparam int         CAC_BIT_IDLE_HALT   = 4;
    localparam int         CAC_BIT_TEN_BIT     = 2;
    localparam int         CAC_BIT_PRESC_EN    = 4;
    localparam int         CAC_BIT_OVF_ZERO    = 3;
    localparam int         CAC_BIT_OVF_ONE     = 7;
    localparam int         CAC_COUNT_WIDTH     = 16;
    localparam int         CAC_PRESC_WIDTH     = 15;
    localparam logic [1:0] CAC_SRC_PRESCALER   = 2'h0;
    localparam logic [1:0] CAC_SRC_TIMER0      = 2'h1;
    localparam logic [1:0] CAC_SRC_EXTERNAL    = 2'h2;
    localparam logic [1:0] CAC_SRC_NONE        = 2'h3;
endpackage : cac_pkg

// *** cac_array_counter.sv ***
/*
 one array's 16-bit counter with clock source selection and prescaler.
 assumes external pin already synchronous and slower than clk/4.
*/
`timescale 1ns/10ps
module cac_array_counter
    import cac_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       srst,
    input  wire logic                       run,
    input  wire logic [1:0]                 clock_select,
    input  wire logic                       presc_enable,
    input  wire logic [3:0]                 presc_exponent,
    input  wire logic                       timer0_overflow,
    input  wire logic                       ext_clock_pin,
    output logic      [CAC_COUNT_WIDTH-1:0] count,
    output logic                            rollover
);
    logic [CAC_PRESC_WIDTH-1:0] presc;
    logic [CAC_PRESC_WIDTH-1:0] next_presc;
    logic [CAC_COUNT_WIDTH-1:0] next_count;
    logic                       ext_last;
    logic                       presc_tick;
    logic                       tick;
    logic                       next_rollover;

    always_comb
    begin
        next_presc = presc + 15'h0001;
        presc_tick = presc_enable;
        // divide by 2^n: tick when low n bits of free counter wrap
        for (int i = 0; i < CAC_PRESC_WIDTH; i++)
        begin
            if (i < int'(presc_exponent) && !presc[i])
            begin
                presc_tick = 1'b0;
            end
        end
        unique case (clock_select) // R6 R15
            CAC_SRC_PRESCALER: tick = presc_tick; // R12
            CAC_SRC_TIMER0:    tick = timer0_overflow;
            CAC_SRC_EXTERNAL:  tick = ext_clock_pin && !ext_last;
            CAC_SRC_NONE:      tick = 1'b0;
        endcase
        next_count    = count;
        next_rollover = 1'b0;
        if (run && tick) // R3
        begin
            next_count    = count + 16'h0001; // R2
            next_rollover = (count == 16'hffff);
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            presc    <= '0;
            count    <= '0;
            ext_last <= 1'b0;
            rollover <= 1'b0;
        end
        else
        begin
            presc    <= next_presc;
            count    <= next_count;
            ext_last <= ext_clock_pin;
            rollover <= next_rollover;
        end
    end

    a_hold_when_stopped: assert property (@(posedge clk) disable iff (srst) // R3
        !run |=> count == $past(count)) else $error("counter moved while stopped");
    a_none_src_holds: assert property (@(posedge clk) disable iff (srst) // R15
        clock_select == CAC_SRC_NONE |=> count == $past(count))
        else $error("counter moved on unassigned source");
    a_timer0_counts: assert property (@(posedge clk) disable iff (srst) // R6
        run && clock_select == CAC_SRC_TIMER0 && timer0_overflow
        |=> count == $past(count) + 16'h0001) else $error("timer0 tick missed");
endmodule : cac_array_counter

// *** cac_counter_array_control.sv ***
/*
 control registers of two counter arrays, prescaler registers, overflow
 flags and interrupt request. assumes one-cycle sfr write/read strobes.
*/
// Functional notes
// R1 - start-all bit 7 of array zero control runs both counters together
// R2 - each started counter is sixteen bits wide
// R3 - counter runs while run bit 6 or start-all bit 7 set; only software changes it
// R4 - idle-halt bit 4 stops the array during cpu idle
// R5 - bit 2 selects ten-bit pwm when 1, sixteen-bit when 0
// R6 - clock source bits 1-0: prescaler, timer 0 overflow, external pin
// R7 - external clock must stay below a quarter of oscillator rate
// R8 - each array has its own control register
// R9 - one shared status register holds both arrays' flags
// R10 - control registers reset to zero
// R11 - overflow flag requests interrupt only when enabled; software clears
// R12 - prescaler divides oscillator by two to the setting, gated by enable
// R13 - software must set all three modules alike for ten-bit pwm
// R14 - reserved control bits read zero, writes ignored
// R15 - clock source code 11 gives no counting clock
`timescale 1ns/10ps
module cac_counter_array_control
    import cac_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       srst,
    input  wire logic [7:0]                 sfr_addr,
    input  wire logic [7:0]                 sfr_wdata,
    input  wire logic                       sfr_write,
    input  wire logic                       sfr_read,
    output logic      [7:0]                 sfr_rdata,
    input  wire logic                       cpu_idle,
    input  wire logic                       timer0_overflow,
    input  wire logic                       ext_clock_zero,
    input  wire logic                       ext_clock_one,
    output logic      [CAC_COUNT_WIDTH-1:0] count_zero,
    output logic      [CAC_COUNT_WIDTH-1:0] count_one,
    output logic                            ten_bit_pwm_zero,
    output logic                            ten_bit_pwm_one,
    output logic                            overflow_irq
);
    logic [7:0] array_control_zero;
    logic [7:0] array_control_one;
    logic [7:0] presc_control_zero;
    logic [7:0] presc_control_one;
    logic [7:0] array_status_register;
    logic [7:0] next_control_zero;
    logic [7:0] next_control_one;
    logic [7:0] next_presc_zero;
    logic [7:0] next_presc_one;
    logic [7:0] next_status;
    logic [7:0] next_rdata;
    logic [1:0] run_array;
    logic [1:0] rollover;
    logic [7:0] ctrl [2];
    logic       next_ten_bit_zero;
    logic       next_ten_bit_one;
    logic       next_irq;

    assign ctrl[0] = array_control_zero;
    assign ctrl[1] = array_control_one;

    // start-all overrides each run bit, idle halt gates both paths
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_run
            assign run_array[g] = (ctrl[g][CAC_BIT_RUN] // R3
                || array_control_zero[CAC_BIT_START_ALL]) // R1
                && !(ctrl[g][CAC_BIT_IDLE_HALT] && cpu_idle); // R4
        end
    endgenerate

    cac_array_counter u_counter_zero (
        .clk             (clk),
        .srst            (srst),
        .run             (run_array[0]),
        .clock_select    (array_control_zero[1:0]),
        .presc_enable    (presc_control_zero[CAC_BIT_PRESC_EN]),
        .presc_exponent  (presc_control_zero[3:0]),
        .timer0_overflow (timer0_overflow),
        .ext_clock_pin   (ext_clock_zero),
        .count           (count_zero),
        .rollover        (rollover[0])
    );

    cac_array_counter u_counter_one (
        .clk             (clk),
        .srst            (srst),
        .run             (run_array[1]),
        .clock_select    (array_control_one[1:0]),
        .presc_enable    (presc_control_one[CAC_BIT_PRESC_EN]),
        .presc_exponent  (presc_control_one[3:0]),
        .timer0_overflow (timer0_overflow),
        .ext_clock_pin   (ext_clock_one),
        .count           (count_one),
        .rollover        (rollover[1])
    );

    always_comb
    begin
        next_control_zero = array_control_zero;
        next_control_one  = array_control_one;
        next_presc_zero   = presc_control_zero;
        next_presc_one    = presc_control_one;
        next_status       = array_status_register;
        next_rdata        = sfr_rdata;
        if (sfr_write)
        begin
            unique case (sfr_addr)
                CAC_ADDR_CTRL_ZERO:  next_control_zero = sfr_wdata & CAC_CTRL_MASK_ZERO; // R8 R14
                CAC_ADDR_CTRL_ONE:   next_control_one  = sfr_wdata & CAC_CTRL_MASK_ONE; // R8 R14
                CAC_ADDR_PRESC_ZERO: next_presc_zero   = sfr_wdata & CAC_PRESC_MASK;
                CAC_ADDR_PRESC_ONE:  next_presc_one    = sfr_wdata & CAC_PRESC_MASK;
                CAC_ADDR_STATUS:     next_status       = sfr_wdata; // R11
                default:             next_status       = array_status_register;
            endcase
        end
        // hardware set wins over a same-cycle software clear
        if (rollover[0])
        begin
            next_status[CAC_BIT_OVF_ZERO] = 1'b1; // R9 R11
        end
        if (rollover[1])
        begin
            next_status[CAC_BIT_OVF_ONE] = 1'b1; // R9 R11
        end
        if (sfr_read)
        begin
            unique case (sfr_addr)
                CAC_ADDR_CTRL_ZERO:  next_rdata = array_control_zero;
                CAC_ADDR_CTRL_ONE:   next_rdata = array_control_one;
                CAC_ADDR_PRESC_ZERO: next_rdata = presc_control_zero;
                CAC_ADDR_PRESC_ONE:  next_rdata = presc_control_one;
                CAC_ADDR_STATUS:     next_rdata = array_status_register;
                default:             next_rdata = 8'h00;
            endcase
        end
        next_ten_bit_zero = array_control_zero[CAC_BIT_TEN_BIT]; // R5
        next_ten_bit_one  = array_control_one[CAC_BIT_TEN_BIT]; // R5
        // irq follows the registered flags, one cycle after they set
        next_irq = (array_status_register[CAC_BIT_OVF_ZERO]
                    && array_control_zero[CAC_BIT_OVF_IRQ_EN])
                || (array_status_register[CAC_BIT_OVF_ONE]
                    && array_control_one[CAC_BIT_OVF_IRQ_EN]); // R11
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            array_control_zero    <= CAC_CTRL_RESET; // R10
            array_control_one     <= CAC_CTRL_RESET; // R10
            presc_control_zero    <= CAC_PRESC_RESET;
            presc_control_one     <= CAC_PRESC_RESET;
            array_status_register <= CAC_STATUS_RESET;
            sfr_rdata             <= 8'h00;
            ten_bit_pwm_zero      <= 1'b0;
            ten_bit_pwm_one       <= 1'b0;
            overflow_irq          <= 1'b0;
        end
        else
        begin
            array_control_zero    <= next_control_zero;
            array_control_one     <= next_control_one;
            presc_control_zero    <= next_presc_zero;
            presc_control_one     <= next_presc_one;
            array_status_register <= next_status;
            sfr_rdata             <= next_rdata;
            ten_bit_pwm_zero      <= next_ten_bit_zero;
            ten_bit_pwm_one       <= next_ten_bit_one;
            overflow_irq          <= next_irq;
        end
    end

    a_start_all_runs: assert property (@(posedge clk) disable iff (srst) // R1
        array_control_zero[CAC_BIT_START_ALL] && !cpu_idle |-> run_array == 2'b11)
        else $error("start-all did not run both");
    a_run_bit_kept: assert property (@(posedge clk) disable iff (srst) // R3
        !(sfr_write && sfr_addr == CAC_ADDR_CTRL_ONE)
        |=> array_control_one[CAC_BIT_RUN] == $past(array_control_one[CAC_BIT_RUN]))
        else $error("run bit changed without write");
    a_run_zero_kept: assert property (@(posedge clk) disable iff (srst) // R3
        !(sfr_write && sfr_addr == CAC_ADDR_CTRL_ZERO)
        |=> array_control_zero[CAC_BIT_RUN] == $past(array_control_zero[CAC_BIT_RUN]))
        else $error("run bit zero changed without write");
    a_idle_halts: assert property (@(posedge clk) disable iff (srst) // R4
        cpu_idle && array_control_one[CAC_BIT_IDLE_HALT] |-> !run_array[1])
        else $error("array ran in idle with halt set");
    a_idle_halts_zero: assert property (@(posedge clk) disable iff (srst) // R4
        cpu_idle && array_control_zero[CAC_BIT_IDLE_HALT] |-> !run_array[0])
        else $error("array zero ran in idle with halt set");
    a_pwm_width: assert property (@(posedge clk) disable iff (srst) // R5
        1'b1 |=> ten_bit_pwm_zero == $past(array_control_zero[CAC_BIT_TEN_BIT]))
        else $error("pwm width select mismatch");
    a_pwm_width_one: assert property (@(posedge clk) disable iff (srst) // R5
        1'b1 |=> ten_bit_pwm_one == $past(array_control_one[CAC_BIT_TEN_BIT]))
        else $error("pwm width select one mismatch");
    a_reset_zero: assert property (@(posedge clk) // R10
        srst |=> array_control_zero == 8'h00 && array_control_one == 8'h00)
        else $error("control not cleared by reset");
    a_reserved_zero: assert property (@(posedge clk) disable iff (srst) // R14
        array_control_one[7] == 1'b0 && array_control_zero[3] == 1'b0
        && array_control_one[3] == 1'b0) else $error("reserved bit set");
    a_ovf_sticky: assert property (@(posedge clk) disable iff (srst) // R9
        rollover[0] |=> array_status_register[CAC_BIT_OVF_ZERO])
        else $error("overflow flag lost");
    a_ovf_one_sticky: assert property (@(posedge clk) disable iff (srst) // R9
        rollover[1] |=> array_status_register[CAC_BIT_OVF_ONE])
        else $error("overflow flag one lost");
    a_irq_gated: assert property (@(posedge clk) disable iff (srst) // R11
        !array_control_zero[CAC_BIT_OVF_IRQ_EN] && !array_control_one[CAC_BIT_OVF_IRQ_EN]
        |=> !overflow_irq) else $error("irq without enable");
    a_irq_raised: assert property (@(posedge clk) disable iff (srst) // R11
        array_status_register[CAC_BIT_OVF_ONE] && array_control_one[CAC_BIT_OVF_IRQ_EN]
        |=> overflow_irq) else $error("enabled overflow gave no irq");

    c_start_all: cover property (@(posedge clk) array_control_zero[CAC_BIT_START_ALL]
        && run_array == 2'b11);
    // flag lands one cycle after the wrap, irq one cycle after the flag
    c_rollover: cover property (@(posedge clk) rollover[0] ##2 overflow_irq);
    c_idle_halt: cover property (@(posedge clk) cpu_idle && !run_array[0]
        && array_control_zero[CAC_BIT_RUN]);
    c_idle_runs: cover property (@(posedge clk) cpu_idle && run_array[1]);
endmodule : cac_counter_array_control

// *** cac_cpu.sv ***
/*
 cpu-side partner: issues one-cycle sfr write and read strobes.
 assumes tasks are called from one bench process, at or after an edge.
*/
`timescale 1ns/10ps
module cac_cpu
(
    input  wire logic       clk,
    output logic      [7:0] sfr_addr,
    output logic      [7:0] sfr_wdata,
    output logic            sfr_write,
    output logic            sfr_read,
    input  wire logic [7:0] sfr_rdata
);
    initial
    begin
        {sfr_addr, sfr_wdata, sfr_write, sfr_read} = '0;
    end

    // ten-bit pwm only with matching module modes, none modelled
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_write <= 1'b1;
        @(posedge clk);
        sfr_write <= 1'b0;
        // released bus shows inverted value, never a stale copy
        sfr_addr  <= ~a;
        sfr_wdata <= ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_read <= 1'b1;
        @(posedge clk);
        sfr_read <= 1'b0;
        sfr_addr <= ~a;
        #1;
        d = sfr_rdata;
    endtask : rd
endmodule : cac_cpu

// *** cac_counter_array_control_bench.sv ***
/*
 self-checking bench for the counter array control block.
 assumes the cac_cpu partner and registered read data one cycle late.
*/
`timescale 1ns/10ps
module cac_counter_array_control_bench
    import cac_pkg::*;
;
    logic        clk, srst, cpu_idle, timer0_overflow, ext_clock_zero, ext_clock_one;
    logic  [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic        sfr_write, sfr_read, ten_bit_pwm_zero, ten_bit_pwm_one, overflow_irq;
    logic [15:0] count_zero, count_one;
    integer      seed = 32201;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          k;
    logic  [7:0] d;

    cac_cpu cac_cpu_i (.clk(clk), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_write(sfr_write), .sfr_read(sfr_read), .sfr_rdata(sfr_rdata));

    cac_counter_array_control cac_counter_array_control_i (.clk(clk), .srst(srst),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_write(sfr_write),
        .sfr_read(sfr_read), .sfr_rdata(sfr_rdata), .cpu_idle(cpu_idle),
        .timer0_overflow(timer0_overflow), .ext_clock_zero(ext_clock_zero),
        .ext_clock_one(ext_clock_one), .count_zero(count_zero), .count_one(count_one),
        .ten_bit_pwm_zero(ten_bit_pwm_zero), .ten_bit_pwm_one(ten_bit_pwm_one),
        .overflow_irq(overflow_irq));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic end_sim();
        if (n_fail == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check8

    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check16

    function automatic logic [7:0] ctrl_exp(input logic [7:0] a, input logic [7:0] v);
        return v & ((a == CAC_ADDR_CTRL_ZERO) ? CAC_CTRL_MASK_ZERO : CAC_CTRL_MASK_ONE);
    endfunction : ctrl_exp

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        cac_cpu_i.rd(a, v);
        check8(v, e);
    endtask : rchk

    // pin period of four clocks: the fastest the far side may toggle
    task automatic pulses(input int n);
        repeat (n)
        begin
            @(posedge clk);
            timer0_overflow <= 1'b1;
            {ext_clock_zero, ext_clock_one} <= 2'b11;
            @(posedge clk);
            timer0_overflow <= 1'b0;
            @(posedge clk);
            {ext_clock_zero, ext_clock_one} <= 2'b00;
            @(posedge clk);
        end
    endtask : pulses

    // counts gained by both arrays over a window; relative, so history is free
    task automatic meas(input logic [7:0] v0, v1, input int cyc, pul,
                        input logic [15:0] e0, e1);
        logic [15:0] s0, s1;
        cac_cpu_i.wr(CAC_ADDR_CTRL_ZERO, v0);
        cac_cpu_i.wr(CAC_ADDR_CTRL_ONE, v1);
        repeat (2) @(posedge clk);
        #1;
        s0 = count_zero;
        s1 = count_one;
        pulses(pul);
        repeat (cyc) @(posedge clk);
        #1;
        check16(count_zero - s0, e0);
        check16(count_one - s1, e1);
    endtask : meas

    initial
    begin
        repeat (100000) @(posedge clk);
        n_fail++;
        end_sim();
    end

    initial
    begin
        {srst, cpu_idle, timer0_overflow, ext_clock_zero, ext_clock_one} = 5'b10000;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rchk(CAC_ADDR_CTRL_ZERO, 8'h00);
        rchk(CAC_ADDR_CTRL_ONE, 8'h00);
        rchk(8'h00, 8'h00);
        check16(count_zero, 16'h0000);
        cac_cpu_i.wr(CAC_ADDR_CTRL_ONE, 8'h20);
        cac_cpu_i.wr(CAC_ADDR_CTRL_ZERO, 8'h80);
        k = 0;
        while (count_zero !== 16'hffff && k < 70000)
        begin
            @(posedge clk);
            #1;
            k++;
        end
        check16(count_zero, 16'hffff);
        repeat (4) @(posedge clk);
        rchk(CAC_ADDR_STATUS, 8'h88);
        check8({7'h00, overflow_irq}, 8'h01);
        cac_cpu_i.wr(CAC_ADDR_CTRL_ONE, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        check8({7'h00, overflow_irq}, 8'h00);
        rchk(CAC_ADDR_CTRL_ZERO, 8'h80);
        cac_cpu_i.wr(CAC_ADDR_STATUS, 8'h00);
        rchk(CAC_ADDR_STATUS, 8'h00);
        // software-set flag on array zero, gated by its own enable
        cac_cpu_i.wr(CAC_ADDR_CTRL_ZERO, 8'ha0);
        cac_cpu_i.wr(CAC_ADDR_STATUS, 8'h08);
        repeat (2) @(posedge clk);
        #1;
        check8({7'h00, overflow_irq}, 8'h01);
        cac_cpu_i.wr(CAC_ADDR_CTRL_ZERO, 8'h80);
        repeat (2) @(posedge clk);
        #1;
        check8({7'h00, overflow_irq}, 8'h00);
        cac_cpu_i.wr(CAC_ADDR_STATUS, 8'h00);
        repeat (4)
        begin
            d = 8'($random(seed));
            cac_cpu_i.wr(CAC_ADDR_CTRL_ZERO, d);
            rchk(CAC_ADDR_CTRL_ZERO, ctrl_exp(CAC_ADDR_CTRL_ZERO, d));
            cac_cpu_i.wr(CAC_ADDR_CTRL_ONE, ~d);
            rchk(CAC_ADDR_CTRL_ONE, ctrl_exp(CAC_ADDR_CTRL_ONE, ~d));
        end
        meas(8'h04, 8'h00, 1, 0, 0, 0);
        check8({6'h00, ten_bit_pwm_zero, ten_bit_pwm_one}, 8'h02);
        meas(8'h00, 8'h04, 1, 0, 0, 0);
        check8({6'h00, ten_bit_pwm_zero, ten_bit_pwm_one}, 8'h01);
        for (int e = 0; e < 4; e++)
        begin
            cac_cpu_i.wr(CAC_ADDR_PRESC_ZERO, 8'h10 | e[7:0]);
            cac_cpu_i.wr(CAC_ADDR_PRESC_ONE, 8'h10 | e[7:0]);
            meas(8'h40, 8'h40, 16, 0, 16'd16 >> e, 16'd16 >> e);
        end
        cac_cpu_i.wr(CAC_ADDR_PRESC_ZERO, 8'h00);
        meas(8'h40, 8'h40, 16, 0, 0, 2);
        cac_cpu_i.wr(CAC_ADDR_PRESC_ZERO, 8'h10);
        cac_cpu_i.wr(CAC_ADDR_PRESC_ONE, 8'h10);
        meas(8'h00, 8'h00, 10, 0, 0, 0);
        meas(8'h80, 8'h00, 12, 0, 12, 12);
        k = 1 + ($unsigned($random(seed)) % 8);
        meas(8'h41, 8'h41, 3, k, k[15:0], k[15:0]);
        meas(8'h42, 8'h42, 3, k, k[15:0], k[15:0]);
        meas(8'h43, 8'h43, 3, k, 0, 0);
        @(posedge clk);
        cpu_idle <= 1'b1;
        meas(8'h50, 8'h40, 8, 0, 0, 8);
        @(posedge clk);
        cpu_idle <= 1'b0;
        end_sim();
    end
endmodule : cac_counter_array_control_bench
